// ===== mco_defines.svh
// constants for the option-configured clock, reset and timer block
// assumes a single 250 MHz reference clock drives all logic
`ifndef MCO_DEFINES_SVH
`define MCO_DEFINES_SVH

// reference clock
`define MCO_REF_KHZ 250000
`define MCO_REF_PERIOD_PS 4000

// cpu clock window and backup oscillator rate
`define MCO_CPU_MIN_KHZ 16'd250
`define MCO_CPU_MAX_KHZ 16'd8000
`define MCO_PROBE_TOP_KHZ 16'd16000
`define MCO_BACKUP_KHZ 16'd2000

// oscillator source select codes
`define MCO_OSC_EXT 3'h4

// supervisor periods in ps; least time rounds down, longest rounds up
`define MCO_FAST_MIN_PS 62500
`define MCO_FAST_MAX_PS 125000
`define MCO_MED_MAX_PS 250000
`define MCO_MPWR_MAX_PS 500000
`define MCO_LOWP_MAX_PS 1000000
`define MCO_CYC_FLOOR(ps) ((ps) / `MCO_REF_PERIOD_PS)
`define MCO_CYC_CEIL(ps) (((ps) + `MCO_REF_PERIOD_PS - 1) / `MCO_REF_PERIOD_PS)

// reset and halt-exit lengths in cpu cycles
`define MCO_RST_LONG 13'd4096
`define MCO_RST_SHORT 13'd256

// register offsets
`define MCO_REG_OPTION 8'h00
`define MCO_REG_STATUS 8'h04
`define MCO_REG_MASK 8'h08
`define MCO_REG_STATE 8'h0c
`define MCO_REG_TMRCTL 8'h10
`define MCO_REG_CMPA 8'h14
`define MCO_REG_CMPB 8'h18
`define MCO_REG_CNTA 8'h1c
`define MCO_REG_CNTB 8'h20
`define MCO_REG_CAPA 8'h24
`define MCO_REG_CAPB 8'h28

// option register fields and reset value
`define MCO_OPT_PLL 3
`define MCO_OPT_FREEZE 7
`define MCO_OPT_SUPV 8
`define MCO_OPT_RST256 11
`define MCO_OPT_VDET 12
`define MCO_OPT_WDGHALT 13
`define MCO_OPT_WDGSW 14
`define MCO_OPTION_RST 15'h0003

// status bits
`define MCO_EV_BACKUP 0
`define MCO_EV_HALTRST 1
`define MCO_EV_CMPA 2
`define MCO_EV_CAPA 3
`define MCO_EV_CMPB 4
`define MCO_EV_CAPB 5
`define MCO_EV_W 6

`endif

// ===== mco_pkg.sv
// types shared by the clock option block
// assumes mco_defines.svh supplies the numeric constants
package mco_pkg;
  // cpu phase sequencer states
  typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_HALT, ST_EXIT} mco_phase_t;
endpackage

// ===== mco_timer.sv
// one general timer: prescaler, 16-bit free-running counter, compare, pwm, capture
// assumes tick inputs are one-cycle pulses on ref_clk, already synchronised
module mco_timer import mco_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // count sources
  input wire logic cntTick,
  input wire logic extTick,
  input wire logic extSel,
  input wire logic [1:0] presc,
  // compare and capture
  input wire logic [15:0] cmpVal,
  input wire logic capPulse,
  // results
  output logic [15:0] count,
  output logic [15:0] capVal,
  output logic cmpEvt,
  output logic capEvt,
  output logic pwmOut
);
  logic [2:0] preCnt_q; // prescaler phase
  logic [2:0] preMask; // divide by 1, 2, 4 or 8
  logic srcTick; // selected count source
  logic step; // counter advances this cycle

  assign preMask = 3'((4'h1 << presc) - 4'h1);
  // external source bypasses any freeze applied to cntTick
  assign srcTick = extSel ? extTick : cntTick;
  assign step = srcTick && (preCnt_q == preMask);

  // prescaler
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      preCnt_q <= 3'h0;
    end else if (srcTick) begin
      preCnt_q <= step ? 3'h0 : preCnt_q + 3'h1;
    end
  end

  // free-running counter and compare strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count <= 16'h0000;
      cmpEvt <= 1'b0;
    end else begin
      cmpEvt <= step && (16'(count + 16'h1) == cmpVal);
      if (step) begin
        count <= count + 16'h1;
      end
    end
  end

  // pwm level: high while the counter is below the compare value
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwmOut <= 1'b0;
    end else begin
      pwmOut <= count < cmpVal;
    end
  end

  // input capture
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      capVal <= 16'h0000;
      capEvt <= 1'b0;
    end else begin
      capEvt <= capPulse;
      if (capPulse) begin
        capVal <= count;
      end
    end
  end
endmodule

// ===== mco_clock_option_config.sv
// option-configured clock generation, supervisor, reset/halt sequencing and timers
// assumes one 250 MHz ref_clk; pins from the outside are synchronised here
`include "mco_defines.svh"

module mco_clock_option_config import mco_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  output logic irq,
  // asynchronous pins
  input wire logic ext_osc_in,
  input wire logic timer_ext_clk_in,
  input wire logic debugStopIn,
  input wire logic capAIn,
  input wire logic capBIn,
  // cpu core requests
  input wire logic haltInstr,
  input wire logic wakeupReq,
  input wire logic wdgSwStart,
  // cpu clock and phase
  output logic cpuTick,
  output logic cpuResetActive,
  output logic cpuHalted,
  output logic backupOscActive,
  output logic watchdogActive,
  // voltage detectors
  output logic extVoltDetEn,
  output logic lowVoltDetEn,
  output logic auxVoltDetEn,
  output logic voltThreshLowest,
  // timer outputs
  output logic pwmA,
  output logic pwmB
);
  // ---------------- synchronisers ----------------
  logic [4:0] sync1_q; // first stage, read only by the second
  logic [4:0] sync2_q; // clean levels
  logic [4:0] prev_q; // previous clean levels for edges
  logic extRise, tmrExtRise, dbgStop, capARise, capBRise;

  // two flops per pin, then one more for edge detection
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      prev_q <= 5'h00;
    end else begin
      sync1_q <= {capBIn, capAIn, debugStopIn, timer_ext_clk_in, ext_osc_in};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign extRise = sync2_q[0] && !prev_q[0];
  assign tmrExtRise = sync2_q[1] && !prev_q[1];
  assign dbgStop = sync2_q[2];
  assign capARise = sync2_q[3] && !prev_q[3];
  assign capBRise = sync2_q[4] && !prev_q[4];

  // ---------------- registers ----------------
  logic [14:0] option_q; // source, doubler, slow, freeze, supervisor and reset options
  logic [5:0] status_q; // sticky events, write one to clear
  logic [5:0] mask_q; // interrupt enables
  logic [4:0] tmrCtl_q; // prescalers and timer A clock source
  logic [15:0] cmpA_q, cmpB_q; // compare values
  logic [5:0] events; // one-cycle event pulses
  logic [15:0] cntA, cntB, capA, capB;
  logic [2:0] slowEff; // clamped slow exponent
  logic backup_q;
  mco_phase_t phase_q;
  logic wdgStarted_q;

  // option field views
  logic [2:0] oscSel;
  logic pllOn, freezeOpt, supEn, rst256, voltOpt, wdgHaltRst, wdgSwOpt;
  logic [1:0] rangeSel;
  logic [2:0] slowReq;
  assign oscSel = option_q[2:0];
  assign pllOn = option_q[`MCO_OPT_PLL];
  assign slowReq = option_q[6:4];
  assign freezeOpt = option_q[`MCO_OPT_FREEZE];
  assign supEn = option_q[`MCO_OPT_SUPV];
  assign rangeSel = option_q[10:9];
  assign rst256 = option_q[`MCO_OPT_RST256];
  assign voltOpt = option_q[`MCO_OPT_VDET];
  assign wdgHaltRst = option_q[`MCO_OPT_WDGHALT];
  assign wdgSwOpt = option_q[`MCO_OPT_WDGSW];

  // software writes; options take effect at once
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      option_q <= `MCO_OPTION_RST;
      mask_q <= 6'h00;
      tmrCtl_q <= 5'h00;
      cmpA_q <= 16'hffff;
      cmpB_q <= 16'hffff;
    end else if (regWr) begin
      unique case (regAddr)
        `MCO_REG_OPTION: option_q <= regWrData[14:0];
        `MCO_REG_MASK: mask_q <= regWrData[5:0];
        `MCO_REG_TMRCTL: tmrCtl_q <= regWrData[4:0];
        `MCO_REG_CMPA: cmpA_q <= regWrData;
        `MCO_REG_CMPB: cmpB_q <= regWrData;
        default: ; // status is cleared below; read-only or unmapped: write ignored
      endcase
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_q <= 6'h00;
    end else begin
      status_q <= (status_q & ~((regWr && regAddr == `MCO_REG_STATUS) ? regWrData[5:0] : 6'h00)) | events;
    end
  end

  assign irq = |(status_q & mask_q);

  // read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !regRd) begin
      regRdData <= 16'h0000;
    end else begin
      unique case (regAddr)
        `MCO_REG_OPTION: regRdData <= {1'b0, option_q};
        `MCO_REG_STATUS: regRdData <= {10'h000, status_q};
        `MCO_REG_MASK: regRdData <= {10'h000, mask_q};
        `MCO_REG_STATE: regRdData <= {8'h00, phase_q == ST_RESET, cpuHalted, watchdogActive, backup_q,
                                      1'b0, slowEff};
        `MCO_REG_TMRCTL: regRdData <= {11'h000, tmrCtl_q};
        `MCO_REG_CMPA: regRdData <= cmpA_q;
        `MCO_REG_CMPB: regRdData <= cmpB_q;
        `MCO_REG_CNTA: regRdData <= cntA;
        `MCO_REG_CNTB: regRdData <= cntB;
        `MCO_REG_CAPA: regRdData <= capA;
        `MCO_REG_CAPB: regRdData <= capB;
        default: regRdData <= 16'h0000; // unmapped reads as zero
      endcase
    end
  end

  // ---------------- clock source and doubled-rate tick ----------------
  // cpu rate after doubler/halver and slow shift
  function automatic logic [15:0] cpuKhz(input logic [15:0] dblKhz, input logic pll, input logic [2:0] s);
    cpuKhz = (pll ? dblKhz : (dblKhz >> 2)) >> s;
  endfunction

  // nearest power-of-two slow factor keeping the cpu rate in its window
  function automatic logic [2:0] clampSlow(input logic [15:0] dblKhz, input logic pll, input logic [2:0] req);
    logic [2:0] s;
    s = req;
    for (int i = 0; i < 7; i++) begin
      if (cpuKhz(dblKhz, pll, s) > `MCO_CPU_MAX_KHZ && s != 3'h7) begin
        s = s + 3'h1;
      end
    end
    for (int i = 0; i < 7; i++) begin
      if (cpuKhz(dblKhz, pll, s) < `MCO_CPU_MIN_KHZ && s != 3'h0) begin
        s = s - 3'h1;
      end
    end
    clampSlow = s;
  endfunction

  logic useExt; // external pin drives the clock chain
  logic [15:0] rangeTopKhz; // upper edge of the supervisor range
  logic [15:0] dblKhz; // twice the oscillator rate, in kHz
  assign useExt = (oscSel == `MCO_OSC_EXT) && !backup_q;

  // unknown external rate: the range top bounds it for clamping
  assign rangeTopKhz = `MCO_PROBE_TOP_KHZ >> rangeSel;

  always_comb begin
    if (backup_q) begin
      dblKhz = `MCO_BACKUP_KHZ << 1;
    end else if (useExt) begin
      dblKhz = rangeTopKhz << 1;
    end else begin
      dblKhz = (`MCO_PROBE_TOP_KHZ >> oscSel[1:0]) << 1;
    end
  end

  assign slowEff = clampSlow(dblKhz, pllOn, slowReq);

  // phase accumulator for probe and backup oscillators
  logic [17:0] acc_q;
  logic [18:0] accSum;
  logic accTick;
  assign accSum = {1'b0, acc_q} + {3'h0, dblKhz};
  assign accTick = accSum >= 19'(`MCO_REF_KHZ);

  always_ff @(posedge ref_clk) begin
    if (!rst_n || useExt) begin
      acc_q <= 18'h00000;
    end else begin
      acc_q <= accTick ? 18'(accSum - 19'(`MCO_REF_KHZ)) : accSum[17:0];
    end
  end

  // external period measure; also yields a mid-period tick to double the pin rate
  logic [9:0] period_q, lastPeriod_q;
  logic seen_q; // one full period has been measured
  logic halfHit, dblTick;
  assign halfHit = seen_q && (period_q == (lastPeriod_q >> 1));
  assign dblTick = useExt ? (extRise || halfHit) : accTick;

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !useExt) begin
      period_q <= 10'h000;
      lastPeriod_q <= 10'h000;
      seen_q <= 1'b0;
    end else if (extRise) begin
      period_q <= 10'h001;
      lastPeriod_q <= period_q;
      seen_q <= period_q != 10'h000;
    end else if (period_q != 10'h3ff) begin
      period_q <= period_q + 10'h001;
    end
  end

  // ---------------- clock supervisor ----------------
  logic [9:0] minCyc, maxCyc;
  always_comb begin
    unique case (rangeSel)
      2'h0: maxCyc = 10'(`MCO_CYC_CEIL(`MCO_FAST_MAX_PS));
      2'h1: maxCyc = 10'(`MCO_CYC_CEIL(`MCO_MED_MAX_PS));
      2'h2: maxCyc = 10'(`MCO_CYC_CEIL(`MCO_MPWR_MAX_PS));
      2'h3: maxCyc = 10'(`MCO_CYC_CEIL(`MCO_LOWP_MAX_PS));
    endcase
    minCyc = 10'(`MCO_CYC_FLOOR(`MCO_FAST_MIN_PS)) << rangeSel;
  end

  logic outOfRange;
  assign outOfRange = supEn && useExt &&
                      ((extRise && seen_q && period_q < minCyc) || (period_q > maxCyc));

  // switch to backup is sticky until reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      backup_q <= 1'b0;
    end else if (outOfRange) begin
      backup_q <= 1'b1;
    end
  end
  assign backupOscActive = backup_q;

  // ---------------- cpu divider ----------------
  // doubled rate divided by slow factor, or by four times it with the doubler off
  logic [9:0] divCnt_q, divLast;
  assign divLast = 10'((pllOn ? 11'h1 : 11'h4) << slowEff) - 10'h1;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      divCnt_q <= 10'h000;
      cpuTick <= 1'b0;
    end else begin
      cpuTick <= dblTick && (divCnt_q >= divLast);
      if (dblTick) begin
        divCnt_q <= (divCnt_q >= divLast) ? 10'h000 : divCnt_q + 10'h001;
      end
    end
  end

  // ---------------- reset and halt sequencing ----------------
  logic [12:0] cyc_q;
  logic [12:0] cycLast;
  logic haltReset;
  assign cycLast = (rst256 ? `MCO_RST_SHORT : `MCO_RST_LONG) - 13'h1;
  assign haltReset = phase_q == ST_RUN && haltInstr && watchdogActive && wdgHaltRst;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      phase_q <= ST_RESET;
      cyc_q <= 13'h0000;
    end else begin
      unique case (phase_q)
        ST_RESET, ST_EXIT: begin
          if (cpuTick) begin
            cyc_q <= cyc_q + 13'h1;
            if (cyc_q == cycLast) begin
              phase_q <= ST_RUN;
              cyc_q <= 13'h0000;
            end
          end
        end
        ST_RUN: begin
          if (haltReset) begin
            phase_q <= ST_RESET;
          end else if (haltInstr) begin
            phase_q <= ST_HALT;
          end
        end
        ST_HALT: begin
          if (wakeupReq) begin
            phase_q <= ST_EXIT;
          end
        end
      endcase
    end
  end

  assign cpuResetActive = phase_q == ST_RESET;
  assign cpuHalted = phase_q == ST_HALT || phase_q == ST_EXIT;

  // watchdog start: hardware mode runs at once, software mode waits for a start
  always_ff @(posedge ref_clk) begin
    if (!rst_n || haltReset) begin
      wdgStarted_q <= 1'b0;
    end else if (wdgSwStart) begin
      wdgStarted_q <= 1'b1;
    end
  end
  assign watchdogActive = wdgSwOpt ? wdgStarted_q : 1'b1;

  // ---------------- voltage detectors ----------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      extVoltDetEn <= 1'b0;
      auxVoltDetEn <= 1'b0;
      voltThreshLowest <= 1'b0;
      lowVoltDetEn <= 1'b0;
    end else begin
      extVoltDetEn <= voltOpt;
      auxVoltDetEn <= voltOpt;
      voltThreshLowest <= voltOpt;
      lowVoltDetEn <= voltOpt && !cpuHalted;
    end
  end

  // ---------------- timers ----------------
  logic tmrTick;
  // breakpoint freeze gates only the cpu-derived count source
  assign tmrTick = cpuTick && !(freezeOpt && dbgStop);

  mco_timer u_timerA (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cntTick(tmrTick),
    .extTick(tmrExtRise),
    .extSel(tmrCtl_q[2]),
    .presc(tmrCtl_q[1:0]),
    .cmpVal(cmpA_q),
    .capPulse(capARise),
    .count(cntA),
    .capVal(capA),
    .cmpEvt(events[`MCO_EV_CMPA]),
    .capEvt(events[`MCO_EV_CAPA]),
    .pwmOut(pwmA)
  );

  mco_timer u_timerB (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cntTick(tmrTick),
    .extTick(1'b0),
    .extSel(1'b0),
    .presc(tmrCtl_q[4:3]),
    .cmpVal(cmpB_q),
    .capPulse(capBRise),
    .count(cntB),
    .capVal(capB),
    .cmpEvt(events[`MCO_EV_CMPB]),
    .capEvt(events[`MCO_EV_CAPB]),
    .pwmOut(pwmB)
  );

  assign events[`MCO_EV_BACKUP] = outOfRange && !backup_q;
  assign events[`MCO_EV_HALTRST] = haltReset;

  // ---------------- checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // cycles since the previous cpu tick, for the rate check
  logic [5:0] since_q;
  logic sinceValid_q; // since_q counts from a tick under the current divider setting
  // an option write or a fallback may shorten one interval, so skip it
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (regWr && regAddr == `MCO_REG_OPTION) || outOfRange) begin
      sinceValid_q <= 1'b0;
    end else if (cpuTick) begin
      sinceValid_q <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || cpuTick) begin
      since_q <= 6'h00;
    end else if (since_q != 6'h3f) begin
      since_q <= since_q + 6'h01;
    end
  end

  a_cpu_rate_max: assert property ((cpuTick && !useExt && sinceValid_q) |-> since_q >= 6'd30)
    else $error("cpu tick faster than 8 MHz");
  a_slow_window: assert property (cpuKhz(dblKhz, pllOn, slowEff) >= `MCO_CPU_MIN_KHZ &&
    cpuKhz(dblKhz, pllOn, slowEff) <= `MCO_CPU_MAX_KHZ)
    else $error("clamped cpu rate outside window");
  a_backup_switch: assert property ((supEn && useExt && extRise && seen_q && period_q < minCyc) |=>
    backup_q && !useExt)
    else $error("supervisor did not switch to backup");
  a_reset_early: assert property ((phase_q == ST_RESET && cyc_q != cycLast) |=> phase_q != ST_RUN)
    else $error("reset phase ended before its count");
  a_freeze_hold: assert property ((freezeOpt && dbgStop) |=> $stable(cntB))
    else $error("timer advanced at a breakpoint");
  a_free_count: assert property ((!freezeOpt && cpuTick && tmrCtl_q[4:3] == 2'h0) |=>
    cntB == 16'($past(cntB) + 16'h1))
    else $error("free timer missed a tick");
  a_ext_ungated: assert property ((tmrCtl_q[2] && tmrCtl_q[1:0] == 2'h0 && tmrExtRise && dbgStop) |=>
    cntA == 16'($past(cntA) + 16'h1))
    else $error("external timer clock was frozen");
  a_lowvolt_halt: assert property ((phase_q == ST_HALT) ##1 (phase_q == ST_HALT) |-> !lowVoltDetEn)
    else $error("low-voltage detector on in halt");
  a_halt_reset: assert property ((phase_q == ST_RUN && haltInstr && watchdogActive && wdgHaltRst) |=>
    phase_q == ST_RESET && cyc_q == 13'h0000)
    else $error("halt with watchdog did not reset");
  a_halt_noreset: assert property ((phase_q == ST_RUN && haltInstr && !(watchdogActive && wdgHaltRst)) |=>
    phase_q == ST_HALT)
    else $error("halt did not enter halt mode");
endmodule

// ===== mco_osc_dbg_model.sv
// far-side model: external oscillator, timer external clock pin and debugger stop level
// assumes the bench may change the half-period inputs at any time, also while the block runs
module mco_osc_dbg_model (
  // clock
  input wire logic ref_clk,
  // controls from the bench
  input wire logic [15:0] oscHalf,
  input wire logic [15:0] tmrHalf,
  input wire logic stopReq,
  // pins toward the block
  output logic ext_osc_in,
  output logic timer_ext_clk_in,
  output logic debugStopIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] oscCnt; // ref cycles since last oscillator toggle
  logic [15:0] tmrCnt; // ref cycles since last timer pin toggle

  initial begin
    ext_osc_in = 1'b0;
    timer_ext_clk_in = 1'b0;
    oscCnt = 16'h0000;
    tmrCnt = 16'h0000;
  end

  // oscillator: a zero half-period stops it, modelling a dead crystal
  always @(posedge ref_clk) begin
    if (oscHalf == 16'h0000) begin
      oscCnt <= 16'h0000;
    end else if (oscCnt >= oscHalf - 16'h0001) begin
      oscCnt <= 16'h0000;
      ext_osc_in <= ~ext_osc_in;
    end else begin
      oscCnt <= oscCnt + 16'h0001;
    end
  end

  // timer pin keeps toggling whatever the debugger does
  always @(posedge ref_clk) begin
    if (tmrHalf == 16'h0000) begin
      tmrCnt <= 16'h0000;
    end else if (tmrCnt >= tmrHalf - 16'h0001) begin
      tmrCnt <= 16'h0000;
      timer_ext_clk_in <= ~timer_ext_clk_in;
    end else begin
      tmrCnt <= tmrCnt + 16'h0001;
    end
  end

  // breakpoint level follows the bench request directly
  assign debugStopIn = stopReq;
endmodule

// ===== mco_clock_option_config_tb_top.sv
// self-checking bench for the clock option block
// assumes the far side comes from mco_osc_dbg_model and a 250 MHz ref_clk
`include "mco_defines.svh"
module mco_clock_option_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, regWr, regRd, haltInstr, wakeupReq, wdgSwStart, capAIn, capBIn, stopReq;
  logic [7:0] regAddr;
  logic [15:0] regWrData, regRdData, oscHalf, tmrHalf, rd, rdB;
  logic irq, extOsc, tmrClk, dbgStop, cpuTick, cpuResetActive, cpuHalted, backupOscActive;
  logic watchdogActive, extVoltDetEn, lowVoltDetEn, auxVoltDetEn, voltThreshLowest, pwmA, pwmB;
  int n_errors, cmp_count, tickCnt, t0, d;
  // the doubler is only ever fed 2 or 4 MHz
  logic [15:0] optTab [6] = '{16'h0800, 16'h0802, 16'h080a, 16'h080b, 16'h0863, 16'h0813};
  int expTab [6] = '{0, 0, 0, 0, 2, 1}; // effective slow exponent
  int tickTab [6] = '{64, 16, 64, 32, 2, 4}; // cpu ticks in 2000 ref cycles

  mco_clock_option_config u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq),
    .ext_osc_in(extOsc), .timer_ext_clk_in(tmrClk), .debugStopIn(dbgStop), .capAIn(capAIn),
    .capBIn(capBIn), .haltInstr(haltInstr), .wakeupReq(wakeupReq), .wdgSwStart(wdgSwStart),
    .cpuTick(cpuTick), .cpuResetActive(cpuResetActive), .cpuHalted(cpuHalted),
    .backupOscActive(backupOscActive), .watchdogActive(watchdogActive), .extVoltDetEn(extVoltDetEn),
    .lowVoltDetEn(lowVoltDetEn), .auxVoltDetEn(auxVoltDetEn), .voltThreshLowest(voltThreshLowest),
    .pwmA(pwmA), .pwmB(pwmB));
  mco_osc_dbg_model u_far (.ref_clk(ref_clk), .oscHalf(oscHalf), .tmrHalf(tmrHalf), .stopReq(stopReq),
    .ext_osc_in(extOsc), .timer_ext_clk_in(tmrClk), .debugStopIn(dbgStop));

  // clock generator, 4 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // running count of cpu ticks, used to measure the derived rate
  always @(posedge ref_clk) begin
    if (cpuTick === 1'b1) tickCnt <= tickCnt + 1;
  end

  // compare helper: counts every compare, reports mismatches
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  // one-cycle register read; data stand only in the following cycle
  task automatic rdr(input logic [7:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask

  // synchronous reset held for 16 cycles
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
  endtask

  // bounded wait for the reset phase to end
  task automatic wait_run();
    for (int i = 0; i < 20000 && cpuResetActive !== 1'b0; i++) @(posedge ref_clk);
    chk("reset phase ends", 16'(cpuResetActive), 16'h0000);
  endtask

  // one-cycle pulse on a cpu request line: 0 halt, 1 wakeup, 2 watchdog start
  task automatic req(input int k);
    @(posedge ref_clk);
    if (k == 0) haltInstr <= 1'b1;
    else if (k == 1) wakeupReq <= 1'b1;
    else wdgSwStart <= 1'b1;
    @(posedge ref_clk);
    haltInstr <= 1'b0;
    wakeupReq <= 1'b0;
    wdgSwStart <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // watchdog: the whole sequence needs about 70k cycles
  initial begin
    repeat (95000) @(posedge ref_clk);
    n_errors++;
    complete_run();
  end

  initial begin
    {rst_n, regWr, regRd, haltInstr, wakeupReq, wdgSwStart, capAIn, capBIn, stopReq} = '0;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    oscHalf = 16'h0000;
    tmrHalf = 16'h0000;
    tickCnt = 0;
    do_reset();
    // reset values, unmapped and read-only places
    rdr(`MCO_REG_OPTION, rd); chk("option reset", rd, 16'h0003);
    rdr(`MCO_REG_CMPA, rd); chk("cmpa reset", rd, 16'hffff);
    rdr(8'h40, rd); chk("unmapped read", rd, 16'h0000);
    wr(`MCO_REG_OPTION, 16'h0800); // fast cpu clock, 256-cycle reset phase
    wr(`MCO_REG_STATE, 16'h00ff);
    rdr(`MCO_REG_STATE, rd); chk("reset flag", rd & 16'h0080, 16'h0080);
    wait_run();
    // derived cpu rate and slow clamp for probe sources 0, 2 and 3, doubler and slow request
    for (int i = 0; i < 6; i++) begin
      wr(`MCO_REG_OPTION, optTab[i]);
      repeat (600) @(posedge ref_clk);
      rdr(`MCO_REG_STATE, rd); chk("slow exponent", rd & 16'h0007, 16'(expTab[i]));
      t0 = tickCnt;
      repeat (2000) @(posedge ref_clk);
      d = tickCnt - t0 - tickTab[i];
      chk("cpu rate", 16'(d >= -1 && d <= 1), 16'h0001);
    end
    // halt with watchdog halt reset selected
    wr(`MCO_REG_OPTION, 16'h2800);
    wr(`MCO_REG_MASK, 16'h0002);
    req(0);
    chk("halt reset", 16'(cpuResetActive), 16'h0001);
    chk("irq on", 16'(irq), 16'h0001);
    rdr(`MCO_REG_STATUS, rd); chk("halt reset flag", rd & 16'h0002, 16'h0002);
    wr(`MCO_REG_STATUS, 16'h0002);
    @(posedge ref_clk);
    chk("irq cleared", 16'(irq), 16'h0000);
    wait_run();
    // software watchdog, no halt reset, voltage detectors
    wr(`MCO_REG_OPTION, 16'h5800);
    repeat (3) @(posedge ref_clk);
    chk("wdg off", 16'(watchdogActive), 16'h0000);
    chk("low volt det on", 16'(lowVoltDetEn), 16'h0001);
    chk("ext volt det on", 16'({extVoltDetEn, auxVoltDetEn, voltThreshLowest}), 16'h0007);
    req(2);
    chk("wdg started", 16'(watchdogActive), 16'h0001);
    req(0);
    chk("no halt reset", 16'({cpuResetActive, cpuHalted}), 16'h0001);
    chk("low volt det off in halt", 16'(lowVoltDetEn), 16'h0000);
    req(1);
    t0 = tickCnt;
    for (int i = 0; i < 20000 && cpuHalted !== 1'b0; i++) @(posedge ref_clk);
    d = tickCnt - t0 - 256;
    chk("halt exit length", 16'(d >= -2 && d <= 1), 16'h0001);
    // timers: freeze, free running, external clock and capture
    wr(`MCO_REG_OPTION, 16'h0880);
    stopReq <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rdr(`MCO_REG_CNTA, rd); repeat (200) @(posedge ref_clk); rdr(`MCO_REG_CNTA, rdB);
    chk("frozen", rdB, rd);
    stopReq <= 1'b0;
    repeat (200) @(posedge ref_clk); rdr(`MCO_REG_CNTB, rd); repeat (200) @(posedge ref_clk);
    rdr(`MCO_REG_CNTB, rdB); chk("runs", 16'(rdB != rd), 16'h0001);
    wr(`MCO_REG_OPTION, 16'h0800);
    stopReq <= 1'b1;
    rdr(`MCO_REG_CNTA, rd); repeat (200) @(posedge ref_clk); rdr(`MCO_REG_CNTA, rdB);
    chk("free at stop", 16'(rdB != rd), 16'h0001);
    wr(`MCO_REG_OPTION, 16'h0880);
    wr(`MCO_REG_TMRCTL, 16'h0004);
    tmrHalf <= 16'h000a;
    repeat (40) @(posedge ref_clk);
    rdr(`MCO_REG_CNTA, rd); repeat (400) @(posedge ref_clk); rdr(`MCO_REG_CNTA, rdB);
    d = int'(rdB - rd) - 20;
    chk("ext clock unfrozen", 16'(d >= -1 && d <= 1), 16'h0001);
    capAIn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rdr(`MCO_REG_STATUS, rd); chk("capture event", rd & 16'h0008, 16'h0008);
    chk("pwm a below compare", 16'(pwmA), 16'h0001);
    chk("pwm b below compare", 16'(pwmB), 16'h0001);
    // supervisor on the external source for every range
    for (int r = 0; r < 4; r++) begin
      oscHalf <= 16'(12 << r);
      do_reset();
      wr(`MCO_REG_OPTION, 16'h0904 | 16'(r << 9));
      repeat (3000) @(posedge ref_clk);
      chk("in range", 16'(backupOscActive), 16'h0000);
      oscHalf <= 16'(48 << r);
      repeat (3000) @(posedge ref_clk);
      chk("fallback", 16'(backupOscActive), 16'h0001);
      rdr(`MCO_REG_STATUS, rd); chk("fallback flag", rd & 16'h0001, 16'h0001);
    end
    complete_run();
  end
endmodule
